// ==== design/pem_exception_unit.sv ====
// Purpose: Exception state tracking, prioritisation and vector selection of a small core.
// Assumes: Requests are synchronous to clk_i; the core acknowledges entry and return.
// Notes:   Stacking, tail-chaining and the return sequence belong to the core.
`timescale 1ns/1ps
`include "pem_defs.svh"

// Functional notes
// RULE_01: Every exception is inactive, pending, active, or active and pending.
// RULE_02: Peripheral or software requests make the matching interrupt pending.
// RULE_03: A preempted handler and its preemptor are both active together.
// RULE_04: A new request for an active source gives active and pending.
// RULE_05: Reset is exception one, highest priority, halting the core while held.
// RULE_06: After reset the start address is fetched from the reset slot.
// RULE_07: The nonmaskable slot has fixed priority minus two; not implemented here.
// RULE_08: Fault exception has fixed priority minus one, vector at 0x0c.
// RULE_09: Supervisor call is exception eleven, configurable, vector at 0x2c.
// RULE_10: Pended service request is exception fourteen with configurable priority.
// RULE_11: System tick is exception fifteen, raised by timer zero or software.
// RULE_12: Peripheral interrupts start at exception sixteen, vectors four bytes apart.
// RULE_13: Asynchronous requests may wait while the core retires more instructions.
// RULE_14: The status register returns the exception number being serviced.
// RULE_15: Configurable exceptions can be disabled; reset and fault cannot.
// RULE_16: Thirty-two peripheral interrupts are routed to service routines.
// RULE_17: Fault is the sole fault-handler exception and counts as a system exception.
// RULE_18: Lower value means more urgent; configurable priorities 0 to 3, default 0.
// RULE_19: Equal priorities resolve to the lowest exception number.
// RULE_20: Only strictly higher priority preempts; equal priority stays pending.
// RULE_21: Reserved numbers 4 to 10 and 12 to 13 are never raised.
// RULE_22: Reported interrupt number is exception number minus sixteen.
module pem_exception_unit
   import pem_pkg::*;
#(
   parameter int NUM_IRQ = 32
)
(
   input  wire logic              clk_i,
   input  wire logic              sys_rst_i,
   input  wire logic [7:0]        addr_i,
   input  wire logic [31:0]       wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [31:0]       rdata_o,
   input  wire logic [NUM_IRQ-1:0] irq_i,
   input  wire logic              tick_zero_i,
   input  wire logic              svc_i,
   input  wire logic              fault_i,
   input  wire logic              take_i,
   input  wire logic              return_i,
   output pem_req_t               req_o,
   output logic      [5:0]        exc_num_o,
   output logic      [7:0]        irq_num_o,
   output logic                   core_halt_o,
   output logic                   boot_fetch_o,
   output logic      [31:0]       boot_addr_o
);

   localparam int NUM_EXC = 16 + NUM_IRQ;

   // ****************************************************************
   // State
   // ****************************************************************
   logic [NUM_EXC-1:0] pend_ff;
   logic [NUM_EXC-1:0] act_ff;
   logic [NUM_IRQ-1:0] irq_en_ff;
   logic [2:0]         sys_en_ff;
   logic [1:0]         irq_prio_ff [NUM_IRQ];
   logic [1:0]         svc_prio_ff;
   logic [1:0]         psv_prio_ff;
   logic [1:0]         tick_prio_ff;
   logic [5:0]         cur_ff;
   pem_req_t           req_ff;
   logic [31:0]        rdata_ff;
   logic               halt_ff;
   logic               boot_ff;
   logic [7:0]         irq_num_ff;

   logic [NUM_EXC-1:0] raise;
   logic [NUM_EXC-1:0] sw_clr;
   logic [NUM_EXC-1:0] enabled;
   logic [NUM_EXC-1:0] impl_mask;
   logic [2:0]         rank [NUM_EXC];
   logic [2:0]         cur_rank;
   pem_req_t           nxt_req;
   logic [5:0]         nxt_cur;
   logic [2:0]         nest_rank;
   logic               take_ok;
   logic               ret_ok;

   // Priority rank: fault is 0, configurable value p ranks p+1, thread mode ranks lowest.
   always_comb
   begin
      rank = '{default: `PEM_RANK_THREAD};
      rank[`PEM_EXC_FAULT] = `PEM_RANK_FAULT;                          // RULE_08
      rank[`PEM_EXC_SVC]   = {1'b0, svc_prio_ff} + 3'h1;              // RULE_09
      rank[`PEM_EXC_PSV]   = {1'b0, psv_prio_ff} + 3'h1;              // RULE_10
      rank[`PEM_EXC_TICK]  = {1'b0, tick_prio_ff} + 3'h1;             // RULE_11
      for (int k = 0; k < NUM_IRQ; k++)
      begin
         rank[16+k] = {1'b0, irq_prio_ff[k]} + 3'h1;                   // RULE_18
      end
   end

   // Reset, the nonmaskable slot and reserved numbers have no pending or active storage.
   always_comb
   begin
      impl_mask = '0;                                                  // RULE_21
      impl_mask[`PEM_EXC_NMI]            = 1'b0;                       // RULE_07
      impl_mask[`PEM_EXC_FAULT]          = 1'b1;                       // RULE_17
      impl_mask[`PEM_EXC_SVC]            = 1'b1;
      impl_mask[`PEM_EXC_PSV]            = 1'b1;
      impl_mask[`PEM_EXC_TICK]           = 1'b1;
      impl_mask[NUM_EXC-1:16]            = '1;                         // RULE_16
      enabled = '0;
      enabled[`PEM_EXC_FAULT]            = 1'b1;                       // RULE_15
      enabled[`PEM_EXC_SVC]              = sys_en_ff[`PEM_SC_SVC_EN];
      enabled[`PEM_EXC_PSV]              = sys_en_ff[`PEM_SC_PSV_EN];
      enabled[`PEM_EXC_TICK]             = sys_en_ff[`PEM_SC_TICK_EN];
      enabled[NUM_EXC-1:16]              = irq_en_ff;                  // RULE_15
   end

   // ****************************************************************
   // Request sources
   // ****************************************************************
   always_comb
   begin
      raise  = '0;
      sw_clr = '0;
      raise[`PEM_EXC_FAULT] = fault_i;                                 // RULE_08
      raise[`PEM_EXC_SVC]   = svc_i;                                   // RULE_09
      raise[`PEM_EXC_PSV]   = wr_i && addr_i == `PEM_OFS_SYS_CTRL && wdata_i[`PEM_SC_PSV_SET];   // RULE_10
      raise[`PEM_EXC_TICK]  = tick_zero_i || (wr_i && addr_i == `PEM_OFS_SYS_CTRL && wdata_i[`PEM_SC_TICK_SET]); // RULE_11
      sw_clr[`PEM_EXC_PSV]  = wr_i && addr_i == `PEM_OFS_SYS_CTRL && wdata_i[`PEM_SC_PSV_CLR];
      sw_clr[`PEM_EXC_TICK] = wr_i && addr_i == `PEM_OFS_SYS_CTRL && wdata_i[`PEM_SC_TICK_CLR];
      raise[NUM_EXC-1:16]   = irq_i | ((wr_i && addr_i == `PEM_OFS_PEND_SET) ? wdata_i[NUM_IRQ-1:0] : '0);   // RULE_02
      sw_clr[NUM_EXC-1:16]  = (wr_i && addr_i == `PEM_OFS_PEND_CLR) ? wdata_i[NUM_IRQ-1:0] : '0;
      raise = raise & impl_mask;                                       // RULE_21
   end

   // ****************************************************************
   // Arbitration
   // ****************************************************************
   assign cur_rank = (cur_ff == 6'h00) ? `PEM_RANK_THREAD : rank[cur_ff];

   // Less-or-equal while scanning downward keeps the lowest number on a tie.
   always_comb
   begin
      nxt_req = '0;
      for (int n = NUM_EXC - 1; n >= 0; n--)
      begin
         if (pend_ff[n] && enabled[n] && rank[n] < cur_rank && (!nxt_req.valid || rank[n] <= rank[nxt_req.num]))
         begin
            nxt_req.valid  = 1'b1;                                     // RULE_20
            nxt_req.num    = 6'(n);                                    // RULE_19
            nxt_req.vector = 32'(n) << `PEM_VEC_STEP;                  // RULE_12
         end
      end
   end

   // On return, the interrupted handler is the most urgent one still active.
   always_comb
   begin
      nxt_cur   = 6'h00;
      nest_rank = `PEM_RANK_THREAD;
      for (int n = 0; n < NUM_EXC; n++)
      begin
         if (act_ff[n] && 6'(n) != cur_ff && rank[n] < nest_rank)
         begin
            nxt_cur   = 6'(n);
            nest_rank = rank[n];
         end
      end
   end

   // The request is one cycle old, so entry is checked against the present state too.
   assign take_ok = take_i && req_ff.valid && pend_ff[req_ff.num] && rank[req_ff.num] < cur_rank;   // RULE_13
   assign ret_ok  = return_i && !take_ok && cur_ff != 6'h00;

   // ****************************************************************
   // Exception state
   // ****************************************************************
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         pend_ff    <= '0;
         act_ff     <= '0;
         cur_ff     <= 6'h00;
         irq_num_ff <= 8'hf0;
         req_ff     <= '0;
      end
      else
      begin
         for (int n = 0; n < NUM_EXC; n++)
         begin
            pend_ff[n] <= raise[n] | (pend_ff[n] & ~(sw_clr[n] | (take_ok && 6'(n) == req_ff.num)));   // RULE_04
            act_ff[n]  <= (take_ok && 6'(n) == req_ff.num) | (act_ff[n] & ~(ret_ok && 6'(n) == cur_ff)); // RULE_03
         end
         cur_ff     <= take_ok ? req_ff.num : (ret_ok ? nxt_cur : cur_ff);                     // RULE_14
         irq_num_ff <= {2'b00, (take_ok ? req_ff.num : (ret_ok ? nxt_cur : cur_ff))} - 8'h10;    // RULE_22
         req_ff     <= nxt_req;
      end
   end

   // ****************************************************************
   // Reset handling
   // ****************************************************************
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         halt_ff <= 1'b1;                                              // RULE_05
         boot_ff <= 1'b0;
      end
      else
      begin
         halt_ff <= 1'b0;
         boot_ff <= halt_ff;                                           // RULE_06
      end
   end

   // ****************************************************************
   // Register port
   // ****************************************************************
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         irq_en_ff    <= '0;
         sys_en_ff    <= `PEM_SYS_EN_RST;
         svc_prio_ff  <= `PEM_PRIO_RST;                                // RULE_18
         psv_prio_ff  <= `PEM_PRIO_RST;
         tick_prio_ff <= `PEM_PRIO_RST;
         for (int k = 0; k < NUM_IRQ; k++)
         begin
            irq_prio_ff[k] <= `PEM_PRIO_RST;
         end
      end
      else if (wr_i)
      begin
         case (addr_i)
            `PEM_OFS_IRQ_EN:   irq_en_ff <= wdata_i[NUM_IRQ-1:0];      // RULE_15
            `PEM_OFS_SYS_CTRL: sys_en_ff <= wdata_i[2:0];
            `PEM_OFS_SYS_PRIO:
            begin
               svc_prio_ff  <= wdata_i[1:0];
               psv_prio_ff  <= wdata_i[3:2];
               tick_prio_ff <= wdata_i[5:4];
            end
            `PEM_OFS_PRIO_LO, `PEM_OFS_PRIO_HI:
            begin
               for (int k = 0; k < NUM_IRQ; k++)
               begin
                  if ((k / 16) == (addr_i == `PEM_OFS_PRIO_HI ? 1 : 0))
                  begin
                     irq_prio_ff[k] <= wdata_i[2*(k%16) +: 2];
                  end
               end
            end
            default: ;
         endcase
      end
   end

   // Unmapped offsets read as zero.
   always_ff @(posedge clk_i)
   begin
      rdata_ff <= 32'h0000_0000;
      if (rd_i && !sys_rst_i)
      begin
         case (addr_i)
            `PEM_OFS_IRQ_EN:   rdata_ff[NUM_IRQ-1:0] <= irq_en_ff;
            `PEM_OFS_PEND_SET, `PEM_OFS_PEND_CLR: rdata_ff[NUM_IRQ-1:0] <= pend_ff[NUM_EXC-1:16];
            `PEM_OFS_IRQ_ACT:  rdata_ff[NUM_IRQ-1:0] <= act_ff[NUM_EXC-1:16];
            `PEM_OFS_SYS_CTRL:
            begin
               rdata_ff[2:0] <= sys_en_ff;
               rdata_ff[`PEM_SC_STATE_LSB +: 8] <= {act_ff[`PEM_EXC_TICK], pend_ff[`PEM_EXC_TICK],
                                                    act_ff[`PEM_EXC_PSV], pend_ff[`PEM_EXC_PSV],
                                                    act_ff[`PEM_EXC_SVC], pend_ff[`PEM_EXC_SVC],
                                                    act_ff[`PEM_EXC_FAULT], pend_ff[`PEM_EXC_FAULT]};  // RULE_01
            end
            `PEM_OFS_PRIO_LO, `PEM_OFS_PRIO_HI:
            begin
               for (int k = 0; k < NUM_IRQ; k++)
               begin
                  if ((k / 16) == (addr_i == `PEM_OFS_PRIO_HI ? 1 : 0))
                  begin
                     rdata_ff[2*(k%16) +: 2] <= irq_prio_ff[k];
                  end
               end
            end
            `PEM_OFS_SYS_PRIO: rdata_ff[5:0] <= {tick_prio_ff, psv_prio_ff, svc_prio_ff};
            `PEM_OFS_STATUS:   rdata_ff[15:0] <= {irq_num_ff, 2'b00, cur_ff};                  // RULE_14
            default: ;
         endcase
      end
   end

   assign rdata_o      = rdata_ff;
   assign req_o        = req_ff;
   assign exc_num_o    = cur_ff;                                       // RULE_14
   assign irq_num_o    = irq_num_ff;
   assign core_halt_o  = halt_ff;
   assign boot_fetch_o = boot_ff;
   assign boot_addr_o  = `PEM_RESET_VEC;                               // RULE_06

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   a_reserved_idle: assert property (((pend_ff | act_ff) & ~impl_mask) == '0)   // RULE_21
      else $error("reserved exception slot became pending or active");
   a_irq_pending: assert property (irq_i[0] |=> pend_ff[16])                   // RULE_02
      else $error("peripheral request did not pend");
   a_take_status: assert property (take_ok |=> cur_ff == $past(req_ff.num) && act_ff[cur_ff])   // RULE_14
      else $error("taken exception not active in status");
   a_nest_active: assert property (take_ok && cur_ff != 6'h00 |=> act_ff[$past(cur_ff)])   // RULE_03
      else $error("preempted handler lost its active state");
   a_act_pend: assert property (act_ff[cur_ff] && raise[cur_ff] |=> pend_ff[$past(cur_ff)])   // RULE_04
      else $error("repeat request lost while its handler runs");
   a_fault_first: assert property (pend_ff[3] && cur_ff != 6'h03 |=> req_ff.valid && req_ff.num == 6'h03)   // RULE_08
      else $error("fault exception not chosen first");
   a_strict_pre: assert property (req_ff.valid |-> rank[req_ff.num] < $past(cur_rank))   // RULE_20
      else $error("request without strictly higher priority");
   a_req_vector: assert property (req_ff.valid |-> req_ff.vector == {24'h0, req_ff.num, 2'b00})   // RULE_12
      else $error("vector not four bytes per exception");
   a_irq_number: assert property (irq_num_o + 8'h10 == {2'b00, exc_num_o})   // RULE_22
      else $error("interrupt number not exception minus sixteen");
   a_halt_boot: assert property (disable iff (1'b0) sys_rst_i ##1 !sys_rst_i |=> boot_fetch_o && !core_halt_o)   // RULE_06
      else $error("no boot fetch after reset release");

   c_nested: cover property (take_ok && cur_ff != 6'h00);
   c_act_pend: cover property (act_ff[16] && pend_ff[16]);
   c_tie: cover property (pend_ff[16] && pend_ff[17] && irq_prio_ff[0] == irq_prio_ff[1] && cur_ff == 6'h00);

endmodule : pem_exception_unit

// ==== shared/pem_defs.svh ====
// Purpose: Offsets, field positions, reset values and fixed numbers of the exception unit.
// Assumes: Included by the package users; definitions only.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
`ifndef PEM_DEFS_SVH
`define PEM_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PEM_OFS_IRQ_EN     8'h00
`define PEM_OFS_PEND_SET   8'h04
`define PEM_OFS_PEND_CLR   8'h08
`define PEM_OFS_IRQ_ACT    8'h0c
`define PEM_OFS_SYS_CTRL   8'h10
`define PEM_OFS_PRIO_LO    8'h14
`define PEM_OFS_PRIO_HI    8'h18
`define PEM_OFS_SYS_PRIO   8'h1c
`define PEM_OFS_STATUS     8'h20

// ****************************************************************
// System control fields
// ****************************************************************
`define PEM_SC_SVC_EN      0
`define PEM_SC_PSV_EN      1
`define PEM_SC_TICK_EN     2
`define PEM_SC_PSV_SET     8
`define PEM_SC_TICK_SET    9
`define PEM_SC_PSV_CLR     10
`define PEM_SC_TICK_CLR    11
`define PEM_SC_STATE_LSB   16
`define PEM_SYS_EN_RST     3'h0
`define PEM_PRIO_RST       2'h0

// ****************************************************************
// Exception numbers, vectors and ranks
// ****************************************************************
`define PEM_EXC_RESET      6'h01
`define PEM_EXC_NMI        6'h02
`define PEM_EXC_FAULT      6'h03
`define PEM_EXC_SVC        6'h0b
`define PEM_EXC_PSV        6'h0e
`define PEM_EXC_TICK       6'h0f
`define PEM_EXC_IRQ0       6'h10
`define PEM_RESET_VEC      32'h0000_0004
`define PEM_VEC_STEP       2
`define PEM_RANK_FAULT     3'h0
`define PEM_RANK_THREAD    3'h7

`endif

// ==== shared/pem_pkg.sv ====
// Purpose: Types shared by the exception unit.
// Assumes: Exception numbers fit in six bits.
// Notes:   Numbers live in pem_defs.svh.
package pem_pkg;

   typedef enum logic [1:0]
   {
      PEM_INACTIVE   = 2'b00,
      PEM_PENDING    = 2'b01,
      PEM_ACTIVE     = 2'b10,
      PEM_ACT_PEND   = 2'b11
   } pem_state_t;

   typedef struct packed
   {
      logic        valid;
      logic [5:0]  num;
      logic [31:0] vector;
   } pem_req_t;

endpackage : pem_pkg

// ==== verification/pem_exception_unit_tb_top.sv ====
// Purpose: Self-checking bench of the exception unit.
// Assumes: Register map and timing as handed over with the design.
// Notes:   Each scenario leaves the unit in thread mode with nothing pending.
`timescale 1ns/1ps
module pem_exception_unit_tb_top
   import pem_pkg::*;
();
   logic clk, sys_rst, bus_wr, bus_rd, svc, fault, take, ret, fire, tick_start;
   logic [7:0]  addr, irq_num, tick_load;
   logic [31:0] wdata, rdata, irq, fire_mask, boot_addr, d;
   logic [3:0]  fire_dly;
   logic [5:0]  exc_num;
   logic        tick_zero, halt, boot_fetch;
   pem_req_t    req;
   int          fail_count, tests_run, n;

   pem_exception_unit #(.NUM_IRQ(32)) pem_exception_unit_inst (.clk_i(clk), .sys_rst_i(sys_rst),
      .addr_i(addr), .wdata_i(wdata), .wr_i(bus_wr), .rd_i(bus_rd), .rdata_o(rdata), .irq_i(irq),
      .tick_zero_i(tick_zero), .svc_i(svc), .fault_i(fault), .take_i(take), .return_i(ret),
      .req_o(req), .exc_num_o(exc_num), .irq_num_o(irq_num), .core_halt_o(halt),
      .boot_fetch_o(boot_fetch), .boot_addr_o(boot_addr));

   pem_source_model pem_source_model_inst (.clk_i(clk), .sys_rst_i(sys_rst), .fire_i(fire),
      .fire_mask_i(fire_mask), .fire_dly_i(fire_dly), .tick_start_i(tick_start),
      .tick_load_i(tick_load), .irq_o(irq), .tick_zero_o(tick_zero));

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic end_of_test;
      if (fail_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr   <= a;
      wdata  <= v;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a);
      @(posedge clk);
      addr   <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1;
      d = rdata;
   endtask : reg_rd

   // Kinds: 0 return, 1 supervisor call, 2 fault, 3 timer start.
   task automatic pulse(input int kind);
      @(posedge clk);
      ret        <= (kind == 0);
      svc        <= (kind == 1);
      fault      <= (kind == 2);
      tick_start <= (kind == 3);
      @(posedge clk);
      {ret, svc, fault, tick_start} <= 4'h0;
   endtask : pulse

   task automatic fire_irq(input logic [31:0] m, input logic [3:0] dl);
      @(posedge clk);
      fire      <= 1'b1;
      fire_mask <= m;
      fire_dly  <= dl;
      @(posedge clk);
      fire <= 1'b0;
      repeat (dl + 3) @(posedge clk);
   endtask : fire_irq

   task automatic no_req;
      repeat (4) @(posedge clk);
      #1;
      chk("req_idle", {31'h0, req.valid}, 32'h0);
   endtask : no_req

   task automatic expect_req(input logic [5:0] num);
      n = 0;
      while (req.valid !== 1'b1 && n < 40)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("req", {25'h0, req.valid, req.num}, {25'h0, 1'b1, num});
      chk("req_vector", req.vector, {24'h0, num, 2'b00});
      @(posedge clk);
      take <= 1'b1;
      @(posedge clk);
      take <= 1'b0;
      #1;
      chk("exc_num", {26'h0, exc_num}, {26'h0, num});
   endtask : expect_req

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset;
      #1;
      chk("halt_in_reset", {31'h0, halt}, 32'h1);
      chk("boot_addr", boot_addr, 32'h0000_0004);
      @(posedge clk);
      sys_rst <= 1'b0;
      n = 0;
      repeat (4)
      begin
         @(posedge clk);
         #1;
         n += int'(boot_fetch === 1'b1);
      end
      chk("boot_fetch_count", n, 32'h1);
      chk("halt_after", {31'h0, halt}, 32'h0);
      reg_rd(8'h1c);
      chk("sys_prio_default", d, 32'h0);
      reg_rd(8'h40);
      chk("unmapped", d, 32'h0);
   endtask : t_reset

   task automatic t_irq;
      reg_wr(8'h00, 32'h1);
      fire_irq(32'h1, 4'h0);
      expect_req(6'h10);
      chk("irq_num", {24'h0, irq_num}, 32'h0);
      reg_rd(8'h20);
      chk("status", {16'h0, d[15:0]}, 32'h0010);
      pulse(0);
      reg_wr(8'h00, 32'h6);
      fire_irq(32'h6, 4'h9);
      expect_req(6'h11);
      pulse(0);
      expect_req(6'h12);
      pulse(0);
   endtask : t_irq

   task automatic t_nest;
      reg_wr(8'h14, 32'h680);
      reg_wr(8'h00, 32'h38);
      fire_irq(32'h08, 4'h0);
      expect_req(6'h13);
      fire_irq(32'h10, 4'h1);
      no_req();
      reg_rd(8'h04);
      chk("pend_equal", {29'h0, d[5:3]}, 32'h2);
      fire_irq(32'h20, 4'h0);
      expect_req(6'h15);
      reg_rd(8'h0c);
      chk("both_active", {29'h0, d[5:3]}, 32'h5);
      fire_irq(32'h20, 4'h0);
      reg_rd(8'h04);
      chk("act_and_pend", {29'h0, d[5:3]}, 32'h6);
      pulse(2);
      expect_req(6'h03);
      chk("irq_num_fault", {24'h0, irq_num}, 32'hf3);
      reg_rd(8'h10);
      chk("fault_state", {24'h0, d[23:16]}, 32'h02);
      reg_wr(8'h08, 32'hffff_ffff);
      repeat (3) pulse(0);
      #1;
      chk("thread", {26'h0, exc_num}, 32'h0);
      no_req();
   endtask : t_nest

   task automatic t_system;
      pulse(1);
      no_req();
      reg_rd(8'h10);
      chk("svc_pending", {24'h0, d[23:16]}, 32'h04);
      reg_wr(8'h10, 32'h7);
      expect_req(6'h0b);
      pulse(0);
      reg_wr(8'h10, 32'h107);
      expect_req(6'h0e);
      pulse(0);
      tick_load <= 8'h05;
      pulse(3);
      expect_req(6'h0f);
      pulse(0);
      reg_wr(8'h1c, 32'h0d);
      reg_wr(8'h10, 32'h307);
      expect_req(6'h0f);
      pulse(0);
      expect_req(6'h0e);
      pulse(0);
      no_req();
   endtask : t_system

   // ****************************************************************
   // Clock, monitor, watchdog and main sequence
   // ****************************************************************
   always #5 clk = ~clk;

   always @(posedge clk)
      if (req.valid === 1'b1 && (req.num inside {[6'h04:6'h0a], 6'h0c, 6'h0d}))
         chk("req_reserved", {26'h0, req.num}, 32'h0);

   initial
   begin
      #100000;
      fail_count++;
      end_of_test();
   end

   initial
   begin
      {clk, bus_wr, bus_rd, svc, fault, take, ret, fire, tick_start} = 9'h0;
      {addr, tick_load, fire_dly, wdata, fire_mask} = 84'h0;
      sys_rst    = 1'b1;
      fail_count = 0;
      tests_run  = 0;
      repeat (10) @(posedge clk);
      t_reset();
      t_irq();
      t_nest();
      t_system();
      end_of_test();
   end
endmodule : pem_exception_unit_tb_top

// ==== verification/pem_source_model.sv ====
// Purpose: Model of the peripheral interrupt sources and the system timer.
// Assumes: One clock; each source raises its request as a one-cycle pulse.
// Notes:   A delay lets the bench make the sources answer promptly or slowly.
`timescale 1ns/1ps
module pem_source_model
(
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        fire_i,
   input  wire logic [31:0] fire_mask_i,
   input  wire logic [3:0]  fire_dly_i,
   input  wire logic        tick_start_i,
   input  wire logic [7:0]  tick_load_i,
   output logic      [31:0] irq_o,
   output logic             tick_zero_o
);
   logic [31:0] mask_ff;
   logic [4:0]  dly_ff;
   logic [8:0]  tick_ff;

   // ****************************************************************
   // Peripheral requests
   // ****************************************************************
   always_ff @(posedge clk_i)
   begin
      irq_o <= 32'h0;
      if (sys_rst_i)
      begin
         mask_ff <= 32'h0;
         dly_ff  <= 5'h0;
      end
      else if (fire_i)
      begin
         mask_ff <= fire_mask_i;
         dly_ff  <= {1'b0, fire_dly_i} + 5'h1;
      end
      else if (dly_ff == 5'h1)
      begin
         irq_o  <= mask_ff;
         dly_ff <= 5'h0;
      end
      else if (dly_ff != 5'h0)
         dly_ff <= dly_ff - 5'h1;
   end

   // ****************************************************************
   // System timer, one shot so it never refills pending on its own
   // ****************************************************************
   always_ff @(posedge clk_i)
   begin
      tick_zero_o <= 1'b0;
      if (sys_rst_i)
         tick_ff <= 9'h0;
      else if (tick_start_i)
         tick_ff <= {1'b0, tick_load_i} + 9'h1;
      else if (tick_ff == 9'h1)
      begin
         tick_zero_o <= 1'b1;
         tick_ff     <= 9'h0;
      end
      else if (tick_ff != 9'h0)
         tick_ff <= tick_ff - 9'h1;
   end
endmodule : pem_source_model
